// ==== float_coprocessor_datapath.sv ====
/*
 * floating coprocessor datapath: control decode, four accumulators,
 * constant table with auto-advancing pointer, float arith unit, return bus.
 * assumes the processor keeps the documented waits before reading results.
 */
`timescale 1ns/10ps
// Overview of operation
// - take control and operands, return result
// - arith unit has ports A, B, D
// - D result buffered onto return bus
// - control taken from microword output bus
// - four accumulators, single or double
// - any accumulator feeds A or B
// - D result writable into any accumulator
// - read-only table of 512 constants
// - constant pointer advances automatically
// - constants reach only the A port
// - add, subtract, multiply in listed formats
// - divide in listed formats
// - fix double float to integers
// - float integers, convert double to single
// - shift left or right 0 to 63
// - answer indices C-F, store and read
// - F read bus only, E also saves
// - error word top bit flags range error
module float_coprocessor_datapath (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// external register port
	input wire logic store_i,
	input wire logic read_i,
	input wire logic [3:0] reg_idx_i,
	input wire logic [15:0] y_bus_i,
	input wire logic ck2_i,
	// constant pointer load
	input wire logic ctab_load_i,
	input wire logic [8:0] ctab_ptr_i,
	// return bus
	output logic [15:0] b_bus_o,
	output logic b_bus_oe_o
);
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_OPERANDS = 5'b00010,
		S_DIVCTL = 5'b00100,
		S_BUSY = 5'b01000,
		S_DONE = 5'b10000
	} state_type;

	typedef struct packed {
		logic s;
		logic signed [13:0] e;
		logic [56:0] m;
	} unp_type;

	typedef struct packed {
		state_type st;
		logic [15:0] cw;
		logic [3:0][3:0][15:0] acc;
		logic [3:0][15:0] res;
		logic err;
		logic [8:0] ptr;
		logic [2:0] na;
		logic [2:0] nb;
		logic [2:0] nk;
		logic [1:0] nd;
		logic [1:0] cnt;
		logic [1:0] rdp;
		logic [15:0] bus;
		logic oe;
	} regs_type;

	regs_type r, n;
	logic [63:0] ctab [fcp_pkg::CTAB_DEPTH];
	logic [6:0] op;
	logic [1:0] asrc, daddr, baddr, aaddr;
	logic [5:0] len;
	logic [2:0] need_a, need_b;
	logic [63:0] a_val, b_val;
	logic [64:0] ex;
	logic wr_ctl;

	// value is m * 2^(e - 52); zero when m is zero
	function automatic unp_type unpack(input logic [63:0] v, input logic dbl);
		unp_type u;
		u.s = v[63];
		if (dbl) begin
			u.e = 14'(v[62:52]) - fcp_pkg::BIAS_D;
			u.m = (v[62:52] == 11'h0) ? 57'h0 : {4'h0, 1'b1, v[51:0]};
		end else begin
			u.e = 14'(v[62:55]) - fcp_pkg::BIAS_S;
			u.m = (v[62:55] == 8'h0) ? 57'h0 : {4'h0, 1'b1, v[54:32], 29'h0};
		end
		return u;
	endfunction: unpack

	// truncating pack; out of range gives zero with the error bit set
	function automatic logic [64:0] pack(input unp_type u, input logic dbl);
		int p;
		logic signed [13:0] be;
		logic [56:0] m;
		p = 0;
		for (int i = 0; i < 57; i++)
			if (u.m[i])
				p = i;
		m = (p > 52) ? (u.m >> (p - 52)) : (u.m << (52 - p));
		be = u.e + 14'(p - 52) + (dbl ? fcp_pkg::BIAS_D : fcp_pkg::BIAS_S);
		if (u.m == 57'h0)
			return 65'h0;
		if (dbl)
			return (be <= 0 || be >= 14'sh07FF) ? {1'b1, 64'h0} :
				{1'b0, u.s, be[10:0], m[51:0]};
		return (be <= 0 || be >= 14'sh00FF) ? {1'b1, 64'h0} :
			{1'b0, u.s, be[7:0], m[51:29], 32'h0};
	endfunction: pack

	function automatic unp_type fadd(input unp_type a, input unp_type b);
		unp_type t;
		logic [13:0] d;
		if (a.m == 57'h0)
			return b;
		if (b.m == 57'h0)
			return a;
		if (b.e > a.e) begin
			t = a;
			a = b;
			b = t;
		end
		d = 14'(a.e - b.e);
		b.m = (d > 14'h0038) ? 57'h0 : (b.m >> d);
		t = a;
		if (a.s == b.s)
			t.m = a.m + b.m;
		else if (a.m >= b.m)
			t.m = a.m - b.m;
		else begin
			t.m = b.m - a.m;
			t.s = b.s;
		end
		return t;
	endfunction: fadd

	function automatic unp_type fmul(input unp_type a, input unp_type b, input logic div);
		unp_type t;
		logic [113:0] w;
		t.s = a.s ^ b.s;
		if (div) begin
			w = {a.m, 57'h0} / {57'h0, b.m};
			t.m = 57'(w >> 5);
			t.e = a.e - b.e;
		end else begin
			w = a.m * b.m;
			t.m = 57'(w >> 52);
			t.e = a.e + b.e;
		end
		return t;
	endfunction: fmul

	function automatic logic [64:0] exec(input logic [6:0] o, input logic [63:0] a,
			input logic [63:0] b);
		logic dbl;
		unp_type ua, ub;
		logic signed [63:0] ia, ib, pr;
		logic signed [13:0] lim;
		dbl = o inside {fcp_pkg::OP_ADD_F4, fcp_pkg::OP_SUB_F4, fcp_pkg::OP_MUL_F4,
			fcp_pkg::OP_DIV_F4};
		ua = unpack(a, dbl);
		ub = unpack(b, dbl);
		ia = 64'($signed(a[63:32]));
		ib = 64'($signed(b[63:32]));
		case (o)
			fcp_pkg::OP_ADD_F2, fcp_pkg::OP_ADD_F4: return pack(fadd(ua, ub), dbl);
			fcp_pkg::OP_SUB_F2, fcp_pkg::OP_SUB_F4: begin
				ub.s = ~ub.s;
				return pack(fadd(ua, ub), dbl);
			end
			fcp_pkg::OP_MUL_F2, fcp_pkg::OP_MUL_F4: return pack(fmul(ua, ub, 1'b0), dbl);
			// float divide, zero divisor flags error
			fcp_pkg::OP_DIV_F2, fcp_pkg::OP_DIV_F4:
				return (ub.m == 57'h0) ? {1'b1, 64'h0} : pack(fmul(ua, ub, 1'b1), dbl);
			// count from low six bits of the first word of B
			fcp_pkg::OP_SHR: return {1'b0, a >> b[53:48]};
			fcp_pkg::OP_SHL: return {1'b0, a << b[53:48]};
			fcp_pkg::OP_FT_I1_F4, fcp_pkg::OP_FT_I2_F2, fcp_pkg::OP_FT_I2_F4: begin
				if (o == fcp_pkg::OP_FT_I1_F4)
					ia = 64'($signed(a[63:48]));
				ua.s = ia[63];
				ua.m = 57'(ia[63] ? -ia : ia);
				ua.e = fcp_pkg::MANT_PT;
				return pack(ua, o != fcp_pkg::OP_FT_I2_F2);
			end
			fcp_pkg::OP_CV_F4_F2: return pack(unpack(a, 1'b1), 1'b0);
			fcp_pkg::OP_FX_F4_I1, fcp_pkg::OP_FX_F4_I2: begin
				ua = unpack(a, 1'b1);
				lim = (o == fcp_pkg::OP_FX_F4_I1) ? 14'sh000F : 14'sh001F;
				if (ua.m == 57'h0 || ua.e < 0)
					return 65'h0;
				if (ua.e >= lim)
					return {1'b1, 64'h0};
				ia = 64'(ua.m >> (14'sh0034 - ua.e));
				ia = ua.s ? -ia : ia;
				return (o == fcp_pkg::OP_FX_F4_I1) ? {1'b0, ia[15:0], 48'h0} :
					{1'b0, ia[31:0], 32'h0};
			end
			fcp_pkg::OP_MUL_I2: begin
				pr = ia * ib;
				return {pr[63:31] != {33{pr[31]}}, pr[31:0], 32'h0};
			end
			fcp_pkg::OP_MUL_L2: begin
				pr = {32'h0, a[63:32]} * {32'h0, b[63:32]};
				return {|pr[63:32], pr[31:0], 32'h0};
			end
			fcp_pkg::OP_DIV_I2: begin
				pr = (ib == 0) ? 64'h0 : ia / ib;
				return {ib == 0 || pr[63:31] != {33{pr[31]}}, pr[31:0], 32'h0};
			end
			fcp_pkg::OP_DIV_L2: begin
				pr = (b[63:32] == 32'h0) ? 64'h0 : 64'(a[63:32] / b[63:32]);
				return {b[63:32] == 32'h0, pr[31:0], 32'h0};
			end
			default: return 65'h0;
		endcase
	endfunction: exec

	// words wanted on A and B for each function
	function automatic logic [5:0] op_len(input logic [6:0] o);
		case (o)
			fcp_pkg::OP_FT_I1_F4: return {3'h1, 3'h0};
			fcp_pkg::OP_FT_I2_F2, fcp_pkg::OP_FT_I2_F4: return {3'h2, 3'h0};
			fcp_pkg::OP_CV_F4_F2, fcp_pkg::OP_FX_F4_I1,
				fcp_pkg::OP_FX_F4_I2: return {3'h4, 3'h0};
			fcp_pkg::OP_SHR, fcp_pkg::OP_SHL: return {3'h4, 3'h1};
			fcp_pkg::OP_ADD_F4, fcp_pkg::OP_SUB_F4, fcp_pkg::OP_MUL_F4,
				fcp_pkg::OP_DIV_F4: return {3'h4, 3'h4};
			default: return {3'h2, 3'h2};
		endcase
	endfunction: op_len

	always_comb begin
		for (int i = 0; i < fcp_pkg::CTAB_DEPTH; i++)
			ctab[i] = {1'b0, 2'h1, 9'(i), 52'h0};
	end

	assign op = r.cw[fcp_pkg::CW_OP_MSB:fcp_pkg::CW_OP_LSB];
	assign asrc = r.cw[fcp_pkg::CW_AS_MSB:fcp_pkg::CW_AS_LSB];
	assign daddr = r.cw[fcp_pkg::CW_D_MSB:fcp_pkg::CW_D_LSB];
	assign baddr = r.cw[fcp_pkg::CW_B_MSB:fcp_pkg::CW_B_LSB];
	assign aaddr = r.cw[fcp_pkg::CW_A_MSB:fcp_pkg::CW_A_LSB];
	assign len = op_len(op);
	assign need_a = (asrc == fcp_pkg::SRC_Y) ? len[5:3] : 3'h0;
	assign need_b = (r.cw[fcp_pkg::CW_BS] == fcp_pkg::BSRC_Y) ? len[2:0] : 3'h0;
	// table only on A, accumulators on either port
	assign a_val = (asrc == fcp_pkg::SRC_CTAB) ? ctab[r.ptr] : r.acc[aaddr];
	assign b_val = r.acc[baddr];
	// all arithmetic through A, B and D
	assign ex = exec(op, a_val, b_val);
	// control word from the output bus
	assign wr_ctl = store_i && reg_idx_i == fcp_pkg::IDX_CTL;

	always_comb begin
		n = r;
		n.oe = 1'b0;
		n.bus = 16'h0;
		if (ctab_load_i)
			n.ptr = ctab_ptr_i;
		// only the upper four indices answer
		if (read_i && reg_idx_i >= fcp_pkg::IDX_BOP) begin
			n.oe = 1'b1;
			unique case (reg_idx_i)
				fcp_pkg::IDX_BOP: n.bus = 16'h0;
				fcp_pkg::IDX_AOP: n.bus = {r.err, 15'h0};
				fcp_pkg::IDX_CTL, fcp_pkg::IDX_DIV: begin
					n.bus = r.res[~r.rdp];
					n.rdp = r.rdp + 2'h1;
					// index E also saves into an accumulator
					if (reg_idx_i == fcp_pkg::IDX_CTL) begin
						n.acc[daddr][~r.rdp] = r.res[~r.rdp];
						if (ck2_i) begin
							n.acc[daddr][~(r.rdp + 2'h1)] = r.res[~(r.rdp + 2'h1)];
							n.rdp = r.rdp + 2'h2;
						end
					end
				end
			endcase
		end
		unique case (r.st)
			S_OPERANDS: begin
				// operands land in the addressed accumulators
				if (store_i && reg_idx_i == fcp_pkg::IDX_AOP && r.na < need_a) begin
					n.acc[aaddr][~r.na[1:0]] = y_bus_i;
					n.na = r.na + 3'h1;
				end else if (store_i && r.nb < need_b && (reg_idx_i == fcp_pkg::IDX_BOP
						|| (reg_idx_i == fcp_pkg::IDX_AOP && need_a == 3'h0))) begin
					n.acc[baddr][~r.nb[1:0]] = y_bus_i;
					n.nb = r.nb + 3'h1;
				end
				if (ck2_i && need_a == 3'h0 && need_b == 3'h0)
					n.nk = r.nk + 3'h2;
				if ((need_a == 3'h0 && need_b == 3'h0) ? (n.nk >= len[5:3]) :
						(n.na >= need_a && n.nb >= need_b)) begin
					n.st = op inside {fcp_pkg::OP_DIV_I2, fcp_pkg::OP_DIV_L2,
						fcp_pkg::OP_DIV_F2, fcp_pkg::OP_DIV_F4} ? S_DIVCTL : S_BUSY;
					n.cnt = fcp_pkg::RESULT_WAIT - 2'h1;
				end
			end
			S_DIVCTL: begin
				if (store_i && reg_idx_i == fcp_pkg::IDX_DIV) begin
					n.nd = r.nd + 2'h1;
					if (n.nd >= fcp_pkg::DIV_CTL_WORDS) begin
						n.st = S_BUSY;
						n.cnt = fcp_pkg::DIV_WAIT - 2'h1;
					end
				end
			end
			// latch so a read after the wait sees the result
			S_BUSY: begin
				n.cnt = r.cnt - 2'h1;
				if (r.cnt == 2'h0) begin
					n.res = ex[63:0];
					n.err = ex[64];
					n.rdp = 2'h0;
					n.st = S_DONE;
					if (asrc == fcp_pkg::SRC_CTAB)
						n.ptr = r.ptr + 9'h1;
				end
			end
			S_IDLE, S_DONE: begin
			end
		endcase
		// a new control word restarts the sequence
		if (wr_ctl) begin
			n.cw = y_bus_i;
			n.na = 3'h0;
			n.nb = 3'h0;
			n.nk = 3'h0;
			n.nd = 2'h0;
			n.st = (y_bus_i[fcp_pkg::CW_OP_MSB:fcp_pkg::CW_OP_LSB] == fcp_pkg::OP_CLEAR) ?
				S_IDLE : S_OPERANDS;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.st <= S_IDLE;
		end else begin
			r <= n;
		end
	end

	assign b_bus_o = r.bus;
	assign b_bus_oe_o = r.oe;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_ops_done;
		r.st == S_OPERANDS && !wr_ctl ##1 r.st == S_BUSY;
	endsequence
	sequence s_div_done;
		r.st == S_DIVCTL && !wr_ctl ##1 r.st == S_BUSY;
	endsequence

	chk_result_wait: assert property (s_ops_done |=> (r.st == S_BUSY)[*2] ##1 r.st == S_DONE)
		else $error("result not latched three cycles after operands");
	chk_div_wait: assert property (s_div_done |=> r.st == S_BUSY ##1 r.st == S_DONE)
		else $error("divide result not latched two cycles after control");
	chk_bus_drive: assert property (read_i |=> b_bus_oe_o == $past(reg_idx_i >= fcp_pkg::IDX_BOP))
		else $error("return bus enable wrong for index");
	chk_result_bus: assert property (read_i && reg_idx_i >= fcp_pkg::IDX_CTL
		|=> b_bus_o == $past(r.res[~r.rdp]))
		else $error("return bus does not carry result word");
	chk_err_word: assert property (read_i && reg_idx_i == fcp_pkg::IDX_AOP
		|=> b_bus_o == {$past(r.err), 15'h0})
		else $error("error word does not reflect last operation");
	chk_e_saves: assert property (read_i && reg_idx_i == fcp_pkg::IDX_CTL && !store_i
		|=> r.acc[$past(daddr)][~$past(r.rdp)] == $past(r.res[~r.rdp]))
		else $error("result not saved into accumulator");
	chk_f_keeps: assert property (read_i && reg_idx_i == fcp_pkg::IDX_DIV && !store_i
		|=> $stable(r.acc))
		else $error("index F read changed an accumulator");
	chk_ptr_step: assert property (r.st == S_BUSY && r.cnt == 2'h0 && !ctab_load_i
		&& asrc == fcp_pkg::SRC_CTAB |=> r.ptr == $past(r.ptr) + 9'h1)
		else $error("constant pointer did not advance");
	chk_cw_take: assert property (wr_ctl |=> r.cw == $past(y_bus_i))
		else $error("control word not captured");
endmodule: float_coprocessor_datapath

// ==== fcp_pkg.sv ====
/*
 * constants for the floating coprocessor datapath: register indices,
 * control word fields, opcodes, operand sources and wait counts.
 * assumes a 16-bit microword output bus and return bus.
 */
package fcp_pkg;
	localparam int WORD_W = 16;
	// external register port indices answered by the coprocessor
	localparam logic [3:0] IDX_BOP = 4'hC;
	localparam logic [3:0] IDX_AOP = 4'hD;
	localparam logic [3:0] IDX_CTL = 4'hE;
	localparam logic [3:0] IDX_DIV = 4'hF;
	localparam int ERR_BIT = 15;
	// control word field positions
	localparam int CW_OP_MSB = 15, CW_OP_LSB = 9;
	localparam int CW_AS_MSB = 8, CW_AS_LSB = 7;
	localparam int CW_BS = 6;
	localparam int CW_D_MSB = 5, CW_D_LSB = 4;
	localparam int CW_B_MSB = 3, CW_B_LSB = 2;
	localparam int CW_A_MSB = 1, CW_A_LSB = 0;
	// operand sources
	localparam logic [1:0] SRC_Y = 2'h0;
	localparam logic [1:0] SRC_ACC = 2'h1;
	localparam logic [1:0] SRC_CTAB = 2'h2;
	localparam logic BSRC_Y = 1'b0;
	// function opcodes
	localparam logic [6:0] OP_CLEAR = 7'h00, OP_ADD_F2 = 7'h01, OP_SUB_F2 = 7'h02;
	localparam logic [6:0] OP_ADD_F4 = 7'h03, OP_SUB_F4 = 7'h04, OP_SHR = 7'h05;
	localparam logic [6:0] OP_SHL = 7'h06, OP_FT_I1_F4 = 7'h07, OP_FT_I2_F2 = 7'h08;
	localparam logic [6:0] OP_FT_I2_F4 = 7'h09, OP_CV_F4_F2 = 7'h0A, OP_FX_F4_I1 = 7'h0B;
	localparam logic [6:0] OP_FX_F4_I2 = 7'h0C, OP_MUL_I2 = 7'h0D, OP_MUL_L2 = 7'h0E;
	localparam logic [6:0] OP_MUL_F2 = 7'h0F, OP_MUL_F4 = 7'h10, OP_DIV_I2 = 7'h11;
	localparam logic [6:0] OP_DIV_L2 = 7'h12, OP_DIV_F2 = 7'h13, OP_DIV_F4 = 7'h14;
	// waits in microcycles
	localparam logic [1:0] RESULT_WAIT = 2'h3;
	localparam logic [1:0] DIV_WAIT = 2'h2;
	localparam logic [1:0] DIV_CTL_WORDS = 2'h1;
	localparam int CTAB_DEPTH = 512;
	// exponent biases and mantissa point
	localparam logic [13:0] BIAS_D = 14'h03FF;
	localparam logic [13:0] BIAS_S = 14'h007F;
	localparam logic [13:0] MANT_PT = 14'h0034;
endpackage: fcp_pkg

// ==== processor_model.sv ====
/* micromachine model: issues control words, operands and result reads
   on the coprocessor register port. assumes the port samples on the rising
   edge; this model changes its outputs only at the falling edge. */
`timescale 1ns/10ps
module processor_model (
	// clock
	input wire logic ref_clk_i,
	// register port
	output logic store_o,
	output logic read_o,
	output logic ck2_o,
	output logic [3:0] reg_idx_o,
	output logic [15:0] y_bus_o,
	output logic ctab_load_o,
	output logic [8:0] ctab_ptr_o,
	// return bus
	input wire logic [15:0] b_bus_i,
	input wire logic b_bus_oe_i
);
	logic [15:0] got_bus;
	logic got_oe;
	int slow;
	// raise ck2 with every read while set, for double-speed saves
	logic ck2_rd;
	initial begin
		ck2_rd = 1'b0;
		store_o = 1'b0;
		read_o = 1'b0;
		ck2_o = 1'b0;
		reg_idx_o = 4'h0;
		y_bus_o = 16'h0000;
		ctab_load_o = 1'b0;
		ctab_ptr_o = 9'h000;
		slow = 0;
	end
	// one microcycle; an idle bus inverts its previous data, so every second idle cycle shows the last word again
	task cyc(input logic st, input logic rd, input logic [3:0] idx, input logic [15:0] d);
		@(negedge ref_clk_i);
		got_bus = b_bus_i;
		got_oe = b_bus_oe_i;
		store_o = st;
		read_o = rd;
		ck2_o = rd & ck2_rd;
		reg_idx_o = idx;
		y_bus_o = st ? d : ~y_bus_o;
	endtask: cyc
	task ldptr(input logic [8:0] p);
		@(negedge ref_clk_i);
		ctab_load_o = 1'b1;
		ctab_ptr_o = p;
		@(negedge ref_clk_i);
		ctab_load_o = 1'b0;
		ctab_ptr_o = ~p;
	endtask: ldptr
	task send(input logic [15:0] c, input logic [63:0] a, input int na, input logic [63:0] b,
		input int nb, input logic [3:0] bidx, input logic dv);
		cyc(1'b1, 1'b0, fcp_pkg::IDX_CTL, c);
		for (int i = 0; i < na; i++) cyc(1'b1, 1'b0, fcp_pkg::IDX_AOP, a[63-16*i -: 16]);
		for (int i = 0; i < nb; i++) cyc(1'b1, 1'b0, bidx, b[63-16*i -: 16]);
		if (dv) cyc(1'b1, 1'b0, fcp_pkg::IDX_DIV, 16'h0000);
		repeat ((dv ? 2 : 3) + slow) cyc(1'b0, 1'b0, fcp_pkg::IDX_BOP, 16'h0000);
	endtask: send
	// back-to-back reads; each word is taken the cycle after its read
	task get(input logic [3:0] idx, input int n, output logic [63:0] r, output logic oe);
		r = 64'h0000_0000_0000_0000;
		oe = 1'b1;
		for (int i = 0; i <= n; i++) begin
			cyc(1'b0, i < n, idx, 16'h0000);
			if (i > 0) begin
				r[79-16*i -: 16] = got_bus;
				oe = oe & got_oe;
			end
		end
	endtask: get
endmodule: processor_model

// ==== testbench.sv ====
/* self-checking bench for the coprocessor datapath, expectations from
   integer and real arithmetic. assumes processor_model drives the port. */
`timescale 1ns/10ps
module testbench;
	logic ref_clk_i = 1'b0;
	logic rst_i;
	logic st, rd, ck2, ld, oe_w, oe;
	logic [3:0] idx;
	logic [15:0] y, bb;
	logic [8:0] ptr;
	logic [63:0] r, a, e;
	int n_mismatch, n_tests, seed, x, z;
	logic [6:0] fop [4] = '{fcp_pkg::OP_ADD_F4, fcp_pkg::OP_SUB_F4, fcp_pkg::OP_MUL_F4,
		fcp_pkg::OP_DIV_F4};
	logic [6:0] iop [4] = '{fcp_pkg::OP_MUL_I2, fcp_pkg::OP_MUL_L2, fcp_pkg::OP_DIV_I2,
		fcp_pkg::OP_DIV_L2};
	real fexp [4] = '{9.0, 3.0, 18.0, 2.0};
	always #5 ref_clk_i = ~ref_clk_i;
	float_coprocessor_datapath dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .store_i(st),
		.read_i(rd), .reg_idx_i(idx), .y_bus_i(y), .ck2_i(ck2), .ctab_load_i(ld),
		.ctab_ptr_i(ptr), .b_bus_o(bb), .b_bus_oe_o(oe_w));
	processor_model mm_u (.ref_clk_i(ref_clk_i), .store_o(st), .read_o(rd), .ck2_o(ck2),
		.reg_idx_o(idx), .y_bus_o(y), .ctab_load_o(ld), .ctab_ptr_o(ptr), .b_bus_i(bb),
		.b_bus_oe_i(oe_w));
	// control word: B acc always 1, D acc and A acc given
	function logic [15:0] cw(input logic [6:0] op, input logic [1:0] as, input logic [1:0] d,
		input logic [1:0] aa);
		return {op, as, fcp_pkg::BSRC_Y, d, 2'h1, aa};
	endfunction: cw
	task chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
		n_tests++;
		if (got !== ex) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask: chk
	task res(input string nm, input logic [3:0] i, input int n, input logic [63:0] ex);
		mm_u.get(i, n, r, oe);
		chk(nm, ex, r);
		chk("return enable", 64'(1'b1), 64'(oe));
	endtask: res
	task print_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask: print_verdict
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		seed = 57888;
		n_mismatch = 0;
		n_tests = 0;
		rst_i = 1'b1;
		repeat (6) @(negedge ref_clk_i);
		rst_i = 1'b0;
		chk("reset enable", 64'h0, 64'(oe_w));
		mm_u.cyc(1'b0, 1'b1, 4'h7, 16'h0000);
		mm_u.cyc(1'b0, 1'b0, 4'h7, 16'h0000);
		chk("unanswered index", 64'h0, 64'(mm_u.got_oe));
		for (int k = 0; k < 6; k++) begin
			a = {$random(seed), $random(seed)};
			z = (k == 0) ? 0 : (k == 1) ? 63 : ($random(seed) & 63);
			e = k[0] ? (a >> z) : (a << z);
			mm_u.send(cw(k[0] ? fcp_pkg::OP_SHR : fcp_pkg::OP_SHL, fcp_pkg::SRC_Y, 2'h3, 2'h0), a, 4,
				{10'h0, 6'(z), 48'h0}, 1, fcp_pkg::IDX_BOP, 1'b0);
			res("shift", fcp_pkg::IDX_DIV, 4, e);
		end
		for (int k = 0; k < 4; k++) begin
			x = $random(seed);
			mm_u.send(cw(fcp_pkg::OP_FT_I1_F4, fcp_pkg::SRC_Y, 2'h3, 2'h0), {16'(x), 48'h0}, 1, 64'h0,
				0, fcp_pkg::IDX_BOP, 1'b0);
			res("float", fcp_pkg::IDX_DIV, 4, $realtobits(real'($signed(16'(x)))));
			mm_u.send(cw(fcp_pkg::OP_FX_F4_I2, fcp_pkg::SRC_Y, 2'h3, 2'h0), $realtobits(real'(x)), 4,
				64'h0, 0, fcp_pkg::IDX_BOP, 1'b0);
			res("fix", fcp_pkg::IDX_DIV, 2, {32'(x), 32'h0});
		end
		a = {$random(seed), $random(seed)};
		mm_u.send(cw(fcp_pkg::OP_SHL, fcp_pkg::SRC_Y, 2'h2, 2'h0), a, 4, 64'h0, 1,
			fcp_pkg::IDX_BOP, 1'b0);
		res("saved read", fcp_pkg::IDX_CTL, 4, a);
		a = {$random(seed), $random(seed)};
		mm_u.send(cw(fcp_pkg::OP_SHL, fcp_pkg::SRC_Y, 2'h2, 2'h0), a, 4, 64'h0, 1,
			fcp_pkg::IDX_BOP, 1'b0);
		// double-speed save: bus shows first of each word pair
		mm_u.ck2_rd = 1'b1;
		res("double save", fcp_pkg::IDX_CTL, 2, {a[63:48], a[31:16], 32'h0});
		mm_u.ck2_rd = 1'b0;
		mm_u.send(cw(fcp_pkg::OP_SHL, fcp_pkg::SRC_ACC, 2'h3, 2'h2), {10'h0, 6'd4, 48'h0}, 1, 64'h0,
			0, fcp_pkg::IDX_BOP, 1'b0);
		res("accumulator source", fcp_pkg::IDX_DIV, 4, a << 4);
		mm_u.ldptr(9'h1FE);
		for (int k = 0; k < 2; k++) begin
			mm_u.send(cw(fcp_pkg::OP_SHL, fcp_pkg::SRC_CTAB, 2'h3, 2'h0), 64'h0, 1, 64'h0, 0,
				fcp_pkg::IDX_BOP, 1'b0);
			res("constant", fcp_pkg::IDX_DIV, 4, {3'b001, 9'(9'h1FE + k), 52'h0});
		end
		mm_u.send(cw(fcp_pkg::OP_DIV_F2, fcp_pkg::SRC_Y, 2'h3, 2'h0), {32'h3F80_0000, 32'h0}, 2,
			64'h0, 2, fcp_pkg::IDX_BOP, 1'b1);
		res("zero divide", fcp_pkg::IDX_DIV, 2, 64'h0);
		res("error word", fcp_pkg::IDX_AOP, 1, {16'h8000, 48'h0});
		mm_u.slow = 2;
		for (int k = 0; k < 4; k++) begin
			mm_u.send(cw(fop[k], fcp_pkg::SRC_Y, 2'h3, 2'h0), $realtobits(6.0), 4, $realtobits(3.0), 4,
				fcp_pkg::IDX_BOP, k == 3);
			res("double op", fcp_pkg::IDX_DIV, 4, $realtobits(fexp[k]));
			res("error clear", fcp_pkg::IDX_AOP, 1, 64'h0);
		end
		mm_u.slow = 0;
		for (int k = 0; k < 4; k++) begin
			x = ($random(seed) & 4095) + 1;
			z = ($random(seed) & 127) + 1;
			mm_u.send(cw(iop[k], fcp_pkg::SRC_Y, 2'h3, 2'h0), {32'(x), 32'h0}, 2, {32'(z), 32'h0}, 2,
				fcp_pkg::IDX_BOP, k > 1);
			res("integer op", fcp_pkg::IDX_DIV, 2, {32'(k < 2 ? x * z : x / z), 32'h0});
		end
		print_verdict();
	end
endmodule: testbench
